// ===== hdl/sys_cfg_pkg.sv
// Package of offsets, field positions and reset values for the system configuration bank
package sys_cfg_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0]  OFS_CONFIG_CONTROL   = 8'h00;  // Configuration control
  localparam logic [7:0]  OFS_EXT_BUS_ADDR_CFG = 8'h04;  // External bus address pin config
  localparam logic [7:0]  OFS_UNLOCK_KEY       = 8'h08;  // Unlock key port
  localparam logic [7:0]  OFS_STATUS           = 8'h0C;  // Unlock status and refused count

  // Configuration control field positions
  localparam int unsigned BIT_DMA_PRI     = 25;  // DMA SRAM priority
  localparam int unsigned BIT_CPU_PRI     = 24;  // CPU interrupt SRAM priority
  localparam int unsigned BIT_CAP_ALT     = 17;  // Capture alternate timebase
  localparam int unsigned BIT_CMP_ALT     = 16;  // Compare alternate timebase
  localparam int unsigned BIT_REMAP_LOCK  = 13;  // Pin remap lock
  localparam int unsigned BIT_MODDIS_LOCK = 12;  // Module disable lock
  localparam int unsigned BIT_PERMGP_LOCK = 11;  // Permission group lock
  localparam int unsigned BIT_USB_SSEN    = 8;   // USB sleep clock stop enable

  // Implemented bits of configuration control; all others read zero
  localparam logic [31:0] CFG_IMPL_MASK  = 32'h0303_3900;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;

  // External bus address pin config fields
  localparam int unsigned BIT_EXT_PIN_EN = 31;  // Bus owns pins shared with the parallel port
  localparam int unsigned ADDR_PINS      = 24;  // Address pin enables in bits 23:0
  localparam logic [31:0] EBA_IMPL_MASK  = 32'h80FF_FFFF;
  localparam logic [31:0] EBA_RESET      = 32'h0000_0000;

  // Unlock key words, arbitrary values
  localparam logic [31:0] UNLOCK_KEY1    = 32'hA5A5_0F0F;
  localparam logic [31:0] UNLOCK_KEY2    = 32'h5A5A_F0F0;

  // Unlock sequencer states
  typedef enum logic [1:0]
  {
    UNLK_IDLE = 2'b00,  // Waiting for first key
    UNLK_KEY1 = 2'b01,  // First key seen
    UNLK_OPEN = 2'b10   // Unlocked until next config write or key write
  } unlock_state_t;

endpackage

// ===== hdl/sys_cfg_unlock.sv
// Unlock key sequencer guarding the configuration control register
module sys_cfg_unlock
(
  input  wire logic i_core_clk,   // Core clock
  input  wire logic i_rst,        // Synchronous reset, active high
  input  wire logic i_key_wr,     // Write to the unlock key port
  input  wire logic [31:0] i_key, // Key word written
  input  wire logic i_consume,    // Config control write uses the unlock
  output logic      o_unlocked    // Unlock sequence complete
);

  sys_cfg_pkg::unlock_state_t state_reg;  // Sequencer state

  // Two keys back to back open; a config write or any wrong key closes
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_reg <= sys_cfg_pkg::UNLK_IDLE;
    end
    else if (i_consume)
    begin
      state_reg <= sys_cfg_pkg::UNLK_IDLE;
    end
    else if (i_key_wr)
    begin
      case (state_reg)
        sys_cfg_pkg::UNLK_IDLE:
        begin
          state_reg <= (i_key == sys_cfg_pkg::UNLOCK_KEY1) ?
                       sys_cfg_pkg::UNLK_KEY1 : sys_cfg_pkg::UNLK_IDLE;
        end
        sys_cfg_pkg::UNLK_KEY1:
        begin
          state_reg <= (i_key == sys_cfg_pkg::UNLOCK_KEY2) ?
                       sys_cfg_pkg::UNLK_OPEN : sys_cfg_pkg::UNLK_IDLE;
        end
        default:
        begin
          // Any key write while open restarts the sequence
          state_reg <= sys_cfg_pkg::UNLK_IDLE;
        end
      endcase
    end
  end

  assign o_unlocked = (state_reg == sys_cfg_pkg::UNLK_OPEN);

endmodule

// ===== hdl/ext_bus_pin_mux.sv
// Per-pin ownership mask for the external bus address pins
module ext_bus_pin_mux
(
  input  wire logic        i_mode_select,  // External bus mode select
  input  wire logic [23:0] i_pin_en,       // Stored address pin enables
  output logic      [23:0] o_pin_own       // Pin owned by the bus interface
);

  // One gate per address pin; mode select overrides every enable
  for (genvar g = 0; g < 24; g++)
  begin : g_pin
    assign o_pin_own[g] = i_pin_en[g] & ~i_mode_select;
  end

endmodule

// ===== hdl/system_config_control_regs.sv
// System configuration register bank: arbitration, timebase, locks, USB and bus pins

module system_config_control_regs
(
  input  wire logic        i_core_clk,          // Core clock, 100 MHz
  input  wire logic        i_rst,               // Synchronous reset, active high
  input  wire logic [7:0]  i_addr,              // Register byte address
  input  wire logic [31:0] i_wdata,             // Write data
  input  wire logic        i_wr,                // Write strobe
  input  wire logic        i_rd,                // Read strobe
  output logic      [31:0] o_rdata,             // Read data, cycle after strobe
  input  wire logic        i_sleep,             // Sleep mode active
  input  wire logic        i_cpu_in_irq,        // CPU is servicing an interrupt
  input  wire logic        i_ext_bus_mode,      // External bus mode select
  input  wire logic        i_remap_wr,          // Pin remap register write request
  input  wire logic        i_moddis_wr,         // Module disable register write request
  input  wire logic        i_permgp_wr,         // Permission group register write request
  output logic             o_dma_sram_hipri,    // DMA wins SRAM arbitration
  output logic             o_cpu_sram_hipri,    // CPU wins SRAM arbitration now
  output logic             o_capture_alt_tb,    // Capture units use alternate pair
  output logic             o_compare_alt_tb,    // Compare units use alternate pair
  output logic             o_remap_wr_ok,       // Pin remap write accepted
  output logic             o_moddis_wr_ok,      // Module disable write accepted
  output logic             o_permgp_wr_ok,      // Permission group write accepted
  output logic             o_usb_phy_clk_en,    // USB PHY clock gate enable
  output logic             o_ext_bus_pins_own,  // Bus owns pins shared with parallel port
  output logic      [23:0] o_ext_bus_addr_own   // Bus owns each address pin
);

  logic [31:0] cfg_reg;          // Configuration control store
  logic [31:0] eba_reg;          // Address pin config store
  logic [7:0]  refused_reg;      // Count of refused protected writes
  logic        unlocked;         // Unlock sequence complete
  logic        wr_cfg;           // Write to configuration control
  logic        wr_eba;           // Write to address pin config
  logic        wr_key;           // Write to unlock key port
  logic [23:0] pin_own;          // Per-pin ownership from the mux
  logic        remap_lock;       // Pin remap lock bit
  logic        moddis_lock;      // Module disable lock bit
  logic        permgp_lock;      // Permission group lock bit

  // Address decode of the write strobe
  assign wr_cfg = i_wr & (i_addr == sys_cfg_pkg::OFS_CONFIG_CONTROL);
  assign wr_eba = i_wr & (i_addr == sys_cfg_pkg::OFS_EXT_BUS_ADDR_CFG);
  assign wr_key = i_wr & (i_addr == sys_cfg_pkg::OFS_UNLOCK_KEY);

  assign remap_lock  = cfg_reg[sys_cfg_pkg::BIT_REMAP_LOCK];
  assign moddis_lock = cfg_reg[sys_cfg_pkg::BIT_MODDIS_LOCK];
  assign permgp_lock = cfg_reg[sys_cfg_pkg::BIT_PERMGP_LOCK];

  // Unlock sequencer; any config write closes it again
  sys_cfg_unlock u_unlock
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_key_wr   (wr_key),
    .i_key      (i_wdata),
    .i_consume  (wr_cfg),
    .o_unlocked (unlocked)
  );

  // Address pin ownership gating
  ext_bus_pin_mux u_pin_mux
  (
    .i_mode_select (i_ext_bus_mode),
    .i_pin_en      (eba_reg[sys_cfg_pkg::ADDR_PINS-1:0]),
    .o_pin_own     (pin_own)
  );

  // Configuration control: every implemented bit is unlock protected
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cfg_reg <= sys_cfg_pkg::CFG_RESET;
    end
    else if (wr_cfg && unlocked)
    begin
      // Unused bits are masked so they stay zero
      cfg_reg <= i_wdata & sys_cfg_pkg::CFG_IMPL_MASK;
    end
    // A write without the unlock falls through and stores nothing
  end

  // Address pin config: not protected, upper unused bits masked off
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      eba_reg <= sys_cfg_pkg::EBA_RESET;
    end
    else if (wr_eba)
    begin
      eba_reg <= i_wdata & sys_cfg_pkg::EBA_IMPL_MASK;
    end
  end

  // Refused-write counter, saturating, so software can see lock hits
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      refused_reg <= 8'h00;
    end
    else if (((wr_cfg && !unlocked) ||
              (i_remap_wr && remap_lock) ||
              (i_moddis_wr && moddis_lock) ||
              (i_permgp_wr && permgp_lock)) && (refused_reg != 8'hFF))
    begin
      refused_reg <= refused_reg + 8'h01;
    end
  end

  // Read port: data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= 32'h0000_0000;
    end
    else if (i_rd)
    begin
      case (i_addr)
        sys_cfg_pkg::OFS_CONFIG_CONTROL:
        begin
          o_rdata <= cfg_reg;
        end
        sys_cfg_pkg::OFS_EXT_BUS_ADDR_CFG:
        begin
          o_rdata <= eba_reg;
        end
        sys_cfg_pkg::OFS_STATUS:
        begin
          o_rdata <= {23'h000000, refused_reg, unlocked};
        end
        default:
        begin
          // Key port and unmapped addresses read zero
          o_rdata <= 32'h0000_0000;
        end
      endcase
    end
    else
    begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // Arbitration priority outputs
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_dma_sram_hipri <= 1'b0;
      o_cpu_sram_hipri <= 1'b0;
    end
    else
    begin
      o_dma_sram_hipri <= cfg_reg[sys_cfg_pkg::BIT_DMA_PRI];
      // Priority applies only while an interrupt is being serviced
      o_cpu_sram_hipri <= cfg_reg[sys_cfg_pkg::BIT_CPU_PRI] & i_cpu_in_irq;
    end
  end

  // Timebase selection for capture and compare units
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_capture_alt_tb <= 1'b0;
      o_compare_alt_tb <= 1'b0;
    end
    else
    begin
      o_capture_alt_tb <= cfg_reg[sys_cfg_pkg::BIT_CAP_ALT];
      o_compare_alt_tb <= cfg_reg[sys_cfg_pkg::BIT_CMP_ALT];
    end
  end

  // Write permits for the guarded register groups
  // Registered, so a lock takes effect one cycle after it is stored
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_remap_wr_ok  <= 1'b0;
      o_moddis_wr_ok <= 1'b0;
      o_permgp_wr_ok <= 1'b0;
    end
    else
    begin
      o_remap_wr_ok  <= i_remap_wr & ~remap_lock;
      o_moddis_wr_ok <= i_moddis_wr & ~moddis_lock;
      o_permgp_wr_ok <= i_permgp_wr & ~permgp_lock;
    end
  end

  // USB PHY clock gate: off only in sleep with the stop enable set
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_usb_phy_clk_en <= 1'b1;
    end
    else
    begin
      o_usb_phy_clk_en <= ~(cfg_reg[sys_cfg_pkg::BIT_USB_SSEN] & i_sleep);
    end
  end

  // External bus pin ownership
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_ext_bus_pins_own <= 1'b0;
      o_ext_bus_addr_own <= 24'h000000;
    end
    else
    begin
      o_ext_bus_pins_own <= eba_reg[sys_cfg_pkg::BIT_EXT_PIN_EN];
      o_ext_bus_addr_own <= pin_own;
    end
  end

endmodule

// ===== verification/system_config_control_regs_sva.sv
// Port-level checker for the system configuration register bank
module system_config_control_regs_sva
(
  input wire logic        i_core_clk,          // Core clock
  input wire logic        i_rst,               // Sync reset
  input wire logic [7:0]  i_addr,              // Address
  input wire logic        i_rd,                // Read strobe
  input wire logic [31:0] o_rdata,             // Read data
  input wire logic        i_sleep,             // Sleep active
  input wire logic        i_cpu_in_irq,        // CPU in handler
  input wire logic        i_ext_bus_mode,      // Bus mode select
  input wire logic        i_remap_wr,          // Remap request
  input wire logic        i_moddis_wr,         // Disable request
  input wire logic        i_permgp_wr,         // Group request
  input wire logic        o_cpu_sram_hipri,    // CPU priority
  input wire logic        o_remap_wr_ok,       // Remap accepted
  input wire logic        o_moddis_wr_ok,      // Disable accepted
  input wire logic        o_permgp_wr_ok,      // Group accepted
  input wire logic        o_usb_phy_clk_en,    // USB clock gate
  input wire logic [23:0] o_ext_bus_addr_own   // Address pin owners
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  property p_cfg_rsvd;
    i_rd && (i_addr == sys_cfg_pkg::OFS_CONFIG_CONTROL)
      |=> (o_rdata & ~sys_cfg_pkg::CFG_IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("cfg spare bits set");
  property p_eba_rsvd;
    i_rd && (i_addr == sys_cfg_pkg::OFS_EXT_BUS_ADDR_CFG)
      |=> (o_rdata & ~sys_cfg_pkg::EBA_IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_eba_rsvd: assert property (p_eba_rsvd) else $error("eba spare bits set");
  // An accept pulse needs a request one cycle before
  property p_remap_ok;
    o_remap_wr_ok |-> $past(i_remap_wr);
  endproperty
  a_remap_ok: assert property (p_remap_ok) else $error("remap ok unasked");
  property p_moddis_ok;
    o_moddis_wr_ok |-> $past(i_moddis_wr);
  endproperty
  a_moddis_ok: assert property (p_moddis_ok) else $error("disable ok unasked");
  property p_permgp_ok;
    o_permgp_wr_ok |-> $past(i_permgp_wr);
  endproperty
  a_permgp_ok: assert property (p_permgp_ok) else $error("group ok unasked");
  // Priority only while the CPU services an interrupt
  property p_cpu_pri;
    o_cpu_sram_hipri |-> $past(i_cpu_in_irq);
  endproperty
  a_cpu_pri: assert property (p_cpu_pri) else $error("cpu priority outside irq");
  property p_mode_free;
    i_ext_bus_mode |=> o_ext_bus_addr_own == 24'h00_0000;
  endproperty
  a_mode_free: assert property (p_mode_free) else $error("pins owned in mode one");
  // The clock may only stop while asleep
  property p_usb_awake;
    !i_sleep |=> o_usb_phy_clk_en;
  endproperty
  a_usb_awake: assert property (p_usb_awake) else $error("usb clock stopped awake");
  // Read data fall back to zero in any cycle not following a read strobe
  property p_rdata_idle;
    !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");
endmodule

bind system_config_control_regs system_config_control_regs_sva u_sva (.*);

// ===== verification/tb_system_config_control_regs.sv
// Self-checking bench for the system configuration register bank
module tb_system_config_control_regs;
  timeunit 1ns;
  timeprecision 100ps;

  logic        i_core_clk = 1'b0;     // Core clock
  logic        i_rst      = 1'b1;     // Reset held at start
  logic [7:0]  i_addr     = 8'h00;    // Bus address
  logic [31:0] i_wdata    = 32'h0;    // Bus write data
  logic        i_wr = 1'b0, i_rd = 1'b0;  // Bus strobes
  logic        i_sleep = 1'b0, i_cpu_in_irq = 1'b0, i_ext_bus_mode = 1'b0;  // Levels
  logic        i_remap_wr = 1'b0, i_moddis_wr = 1'b0, i_permgp_wr = 1'b0;  // Guarded requests
  logic [31:0] o_rdata;               // Read data
  logic        o_dma_sram_hipri, o_cpu_sram_hipri, o_capture_alt_tb, o_compare_alt_tb;
  logic        o_remap_wr_ok, o_moddis_wr_ok, o_permgp_wr_ok, o_usb_phy_clk_en;
  logic        o_ext_bus_pins_own;    // Shared pins owner
  logic [23:0] o_ext_bus_addr_own;    // Address pin owners
  int          failures   = 0;        // Mismatch count
  int          num_checks = 0;        // Comparison count

  system_config_control_regs dut (.*);

  // 100 MHz clock
  always #5 i_core_clk = ~i_core_clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Wait n edges, then step past them so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 chk(name, o_rdata, exp);
  endtask

  task automatic unlock;
    wr(sys_cfg_pkg::OFS_UNLOCK_KEY, sys_cfg_pkg::UNLOCK_KEY1);
    wr(sys_cfg_pkg::OFS_UNLOCK_KEY, sys_cfg_pkg::UNLOCK_KEY2);
  endtask

  // All three guarded groups asked at once; accepts come one cycle later
  task automatic grp(input logic exp);
    @(posedge i_core_clk);
    i_remap_wr  <= 1'b1;
    i_moddis_wr <= 1'b1;
    i_permgp_wr <= 1'b1;
    @(posedge i_core_clk);
    i_remap_wr  <= 1'b0;
    i_moddis_wr <= 1'b0;
    i_permgp_wr <= 1'b0;
    #1 chk("grp_ok", 32'({o_remap_wr_ok, o_moddis_wr_ok, o_permgp_wr_ok}), 32'({3{exp}}));
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    tick(1);
    chk("usb_rst", 32'(o_usb_phy_clk_en), 32'h1);
    rdc("cfg_rst", sys_cfg_pkg::OFS_CONFIG_CONTROL, sys_cfg_pkg::CFG_RESET);
    rdc("eba_rst", sys_cfg_pkg::OFS_EXT_BUS_ADDR_CFG, sys_cfg_pkg::EBA_RESET);
    rdc("unmapped", 8'h10, 32'h0000_0000);
    wr(sys_cfg_pkg::OFS_CONFIG_CONTROL, 32'hFFFF_FFFF);
    rdc("cfg_locked", sys_cfg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
    rdc("stat_ref", sys_cfg_pkg::OFS_STATUS, 32'h0000_0002);
    // Read data must drop back to zero one cycle after they stood
    tick(1);
    chk("rdata_idle", o_rdata, 32'h0000_0000);
    unlock();
    rdc("stat_open", sys_cfg_pkg::OFS_STATUS, 32'h0000_0003);
    wr(sys_cfg_pkg::OFS_CONFIG_CONTROL, 32'hFFFF_FFFF);
    rdc("cfg_all", sys_cfg_pkg::OFS_CONFIG_CONTROL, sys_cfg_pkg::CFG_IMPL_MASK);
    // The unlock was used up, so clearing without a new one must not land
    wr(sys_cfg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
    rdc("cfg_kept", sys_cfg_pkg::OFS_CONFIG_CONTROL, sys_cfg_pkg::CFG_IMPL_MASK);
    @(posedge i_core_clk);
    i_cpu_in_irq <= 1'b1;
    i_sleep      <= 1'b1;
    tick(2);
    chk("outs_set", 32'({o_dma_sram_hipri, o_cpu_sram_hipri, o_capture_alt_tb,
        o_compare_alt_tb, o_usb_phy_clk_en}), 32'h1E);
    // Out of the handler and awake: CPU priority drops, USB clock runs
    @(posedge i_core_clk);
    i_cpu_in_irq <= 1'b0;
    i_sleep      <= 1'b0;
    tick(2);
    chk("outs_wake", 32'({o_dma_sram_hipri, o_cpu_sram_hipri, o_capture_alt_tb,
        o_compare_alt_tb, o_usb_phy_clk_en}), 32'h17);
    @(posedge i_core_clk);
    i_cpu_in_irq <= 1'b1;
    i_sleep      <= 1'b1;
    grp(1'b0);
    // Three refused events so far: two locked config writes, one group cycle
    rdc("stat_grp", sys_cfg_pkg::OFS_STATUS, 32'h0000_0006);
    // A wrong key between the two must leave the register closed
    wr(sys_cfg_pkg::OFS_UNLOCK_KEY, sys_cfg_pkg::UNLOCK_KEY1);
    wr(sys_cfg_pkg::OFS_UNLOCK_KEY, 32'h0000_0000);
    wr(sys_cfg_pkg::OFS_UNLOCK_KEY, sys_cfg_pkg::UNLOCK_KEY2);
    rdc("stat_badkey", sys_cfg_pkg::OFS_STATUS, 32'h0000_0006);
    unlock();
    wr(sys_cfg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
    tick(2);
    chk("outs_clr", 32'({o_dma_sram_hipri, o_cpu_sram_hipri, o_capture_alt_tb,
        o_compare_alt_tb, o_usb_phy_clk_en}), 32'h01);
    grp(1'b1);
    wr(sys_cfg_pkg::OFS_EXT_BUS_ADDR_CFG, 32'hFFFF_FFFF);
    rdc("eba_all", sys_cfg_pkg::OFS_EXT_BUS_ADDR_CFG, sys_cfg_pkg::EBA_IMPL_MASK);
    tick(1);
    chk("own_all", 32'({o_ext_bus_pins_own, o_ext_bus_addr_own}), 32'h01FF_FFFF);
    wr(sys_cfg_pkg::OFS_EXT_BUS_ADDR_CFG, 32'h0000_00A5);
    tick(2);
    chk("own_some", 32'({o_ext_bus_pins_own, o_ext_bus_addr_own}), 32'h0000_00A5);
    @(posedge i_core_clk);
    i_ext_bus_mode <= 1'b1;
    tick(2);
    chk("own_mode", 32'(o_ext_bus_addr_own), 32'h0000_0000);
    // Second reset in mid-run must clear the address pin config word and the counter
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rdc("eba_rst2", sys_cfg_pkg::OFS_EXT_BUS_ADDR_CFG, sys_cfg_pkg::EBA_RESET);
    rdc("stat_rst2", sys_cfg_pkg::OFS_STATUS, 32'h0000_0000);
    final_report();
  end

  // Watchdog well beyond the fewer than one hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge i_core_clk);
    failures++;
    final_report();
  end
endmodule
